// [src/uart_port_map.svh]
// constants for the dual-channel host bus port
//
// Overview of operation
// - read strobe falling edge starts a read of the indexed register, byte driven out
// - write starts at write strobe fall; byte sampled while the strobe is low, the last one committed at its rise
// - accesses taken only with chip select low, routed by channel pick
// - channel pick low selects channel B, high selects channel A
// - broadcast bit set makes one write update both channels
// - channel A interrupt output high while channel A requests service, registered one clock later
// - channel B interrupt output high while channel B requests service, registered one clock later
// - each channel has an active-low transmit space flag from its transmit state
// - register data uses one shared eight-bit two-way data bus
`ifndef UART_PORT_MAP_SVH
`define UART_PORT_MAP_SVH

`define PIN_DATA_LSB 0
`define PIN_DATA_MSB 7
`define PIN_INDEX_LSB 8
`define PIN_INDEX_MSB 10
`define PIN_PICK 11
`define PIN_WRITE_N 12
`define PIN_READ_N 13
`define PIN_CS_N 14
`define PIN_WIDTH 15
`define PIN_IDLE_VALUE 15'h7800
`define DATA_RESET 8'h00
`define INDEX_RESET 3'h0

`endif

// [src/uart_port_pkg.sv]
// types for the dual-channel host bus port
package uart_port_pkg;

    typedef enum logic [1:0] {
        PORT_IDLE = 2'b00,
        PORT_RD_FETCH = 2'b01,
        PORT_RD_DRIVE = 2'b10,
        PORT_WR_HOLD = 2'b11
    } port_state_t;

endpackage

// [src/dual_uart_host_bus_port.sv]
// strobe-driven host bus port in front of two uart channels
`timescale 1ns/1ns
`include "uart_port_map.svh"

module dual_uart_host_bus_port
    import uart_port_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int INDEX_WIDTH = 3
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic csN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic channelPick,
    input wire logic [INDEX_WIDTH-1:0] registerIndex,
    input wire logic [DATA_WIDTH-1:0] dataIn,
    output logic [DATA_WIDTH-1:0] dataOut,
    output logic dataOe,
    input wire logic alternateFunctionBroadcast,
    output logic [INDEX_WIDTH-1:0] regIndex,
    output logic [DATA_WIDTH-1:0] regWrData,
    output logic writeChanA,
    output logic writeChanB,
    output logic readChanA,
    output logic readChanB,
    input wire logic [DATA_WIDTH-1:0] readDataA,
    input wire logic [DATA_WIDTH-1:0] readDataB,
    input wire logic pendingA,
    input wire logic pendingB,
    input wire logic txSpaceA,
    input wire logic txSpaceB,
    output logic irqOutChanA,
    output logic irqOutChanB,
    output logic txSpaceFlagAN,
    output logic txSpaceFlagBN
);

    logic [`PIN_WIDTH-1:0] pinMeta_reg;
    logic [`PIN_WIDTH-1:0] pinSync_reg;
    logic [`PIN_WIDTH-1:0] pinPrev_reg;
    logic csLow;
    logic rdLow;
    logic wrLow;
    logic rdFall;
    logic wrFall;
    logic wrRise;
    logic rdEnd;
    port_state_t state_reg;
    port_state_t state_next;
    logic chanA_reg;
    logic chanA_next;
    logic [INDEX_WIDTH-1:0] index_reg;
    logic [INDEX_WIDTH-1:0] index_next;
    logic [DATA_WIDTH-1:0] wrData_reg;
    logic [DATA_WIDTH-1:0] wrData_next;
    logic [DATA_WIDTH-1:0] rdData_reg;
    logic [DATA_WIDTH-1:0] rdData_next;
    logic oe_reg;
    logic oe_next;
    logic [3:0] status_reg;

    // pins pass two flops; a third copy gives the edge history
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pinMeta_reg <= `PIN_IDLE_VALUE;
            pinSync_reg <= `PIN_IDLE_VALUE;
            pinPrev_reg <= `PIN_IDLE_VALUE;
        end
        else
        begin
            pinMeta_reg <= {csN, readStrobeN, writeStrobeN, channelPick, registerIndex, dataIn};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end

    // strobe levels and edges seen on the synchronised copy
    assign csLow = !pinSync_reg[`PIN_CS_N];
    assign rdLow = !pinSync_reg[`PIN_READ_N];
    assign wrLow = !pinSync_reg[`PIN_WRITE_N];
    assign rdFall = rdLow && pinPrev_reg[`PIN_READ_N];
    assign wrFall = wrLow && pinPrev_reg[`PIN_WRITE_N];
    assign wrRise = !wrLow && !pinPrev_reg[`PIN_WRITE_N];
    assign rdEnd = !rdLow || !csLow;

    // access sequencer: next values
    always_comb
    begin
        state_next = state_reg;
        chanA_next = chanA_reg;
        index_next = index_reg;
        wrData_next = wrData_reg;
        rdData_next = rdData_reg;
        readChanA = 1'b0;
        readChanB = 1'b0;
        writeChanA = 1'b0;
        writeChanB = 1'b0;
        case (state_reg)
            PORT_IDLE:
            begin
                if (csLow && rdFall)
                begin
                    // fetch from the indexed register of the picked channel
                    index_next = pinSync_reg[`PIN_INDEX_MSB:`PIN_INDEX_LSB];
                    chanA_next = pinSync_reg[`PIN_PICK];
                    readChanA = pinSync_reg[`PIN_PICK];
                    readChanB = !pinSync_reg[`PIN_PICK];
                    state_next = PORT_RD_FETCH;
                end
                else if (csLow && wrFall)
                begin
                    index_next = pinSync_reg[`PIN_INDEX_MSB:`PIN_INDEX_LSB];
                    chanA_next = pinSync_reg[`PIN_PICK];
                    wrData_next = pinSync_reg[`PIN_DATA_MSB:`PIN_DATA_LSB];
                    state_next = PORT_WR_HOLD;
                end
            end
            PORT_RD_FETCH:
            begin
                // channel answers one cycle after its read pulse
                rdData_next = chanA_reg ? readDataA : readDataB;
                state_next = rdEnd ? PORT_IDLE : PORT_RD_DRIVE;
            end
            PORT_RD_DRIVE:
            begin
                if (rdEnd)
                begin
                    state_next = PORT_IDLE;
                end
            end
            PORT_WR_HOLD:
            begin
                if (wrLow)
                begin
                    wrData_next = pinSync_reg[`PIN_DATA_MSB:`PIN_DATA_LSB];
                end
                else if (wrRise)
                begin
                    // last byte seen while low is committed on the rise
                    writeChanA = chanA_reg || alternateFunctionBroadcast;
                    writeChanB = !chanA_reg || alternateFunctionBroadcast;
                    state_next = PORT_IDLE;
                end
                else
                begin
                    state_next = PORT_IDLE;
                end
            end
            default:
            begin
                state_next = PORT_IDLE;
            end
        endcase
        oe_next = (state_next == PORT_RD_DRIVE) && !rdEnd;
    end

    // access sequencer: registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= PORT_IDLE;
            chanA_reg <= 1'b0;
            index_reg <= `INDEX_RESET;
            wrData_reg <= `DATA_RESET;
            rdData_reg <= `DATA_RESET;
            oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            chanA_reg <= chanA_next;
            index_reg <= index_next;
            wrData_reg <= wrData_next;
            rdData_reg <= rdData_next;
            oe_reg <= oe_next;
        end
    end

    // status outputs registered from the channel cores
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg <= 4'h0;
        end
        else
        begin
            status_reg <= {pendingA, pendingB, txSpaceA, txSpaceB};
        end
    end

    assign dataOut = rdData_reg;
    assign dataOe = oe_reg;
    assign regIndex = index_reg;
    assign regWrData = wrData_reg;
    assign irqOutChanA = status_reg[3];
    assign irqOutChanB = status_reg[2];
    assign txSpaceFlagAN = !status_reg[1];
    assign txSpaceFlagBN = !status_reg[0];

    // checks
    sequence s_readStart;
        csLow && rdFall && (state_reg == PORT_IDLE);
    endsequence

    sequence s_writeDone;
        (state_reg == PORT_WR_HOLD) && wrRise;
    endsequence

    a_read_pulse: assert property (@(posedge clk) disable iff (!resetn)
        s_readStart |-> (readChanA == pinSync_reg[`PIN_PICK]) && (readChanA != readChanB)
        ##1 state_reg == PORT_RD_FETCH)
        else $error("read start did not pulse one channel");

    a_read_capture: assert property (@(posedge clk) disable iff (!resetn)
        readChanA ##1 (state_reg == PORT_RD_FETCH) |=> rdData_reg == $past(readDataA))
        else $error("channel A read byte not captured");

    a_oe_window: assert property (@(posedge clk) disable iff (!resetn)
        dataOe |-> $past(csLow) && $past(rdLow))
        else $error("data bus driven outside read window");

    a_read_release: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == PORT_RD_DRIVE) && rdEnd |=> !dataOe && (state_reg == PORT_IDLE))
        else $error("bus not released after read strobe rise");

    a_write_route: assert property (@(posedge clk) disable iff (!resetn)
        s_writeDone |-> (writeChanA || writeChanB) && regWrData == $past(pinSync_reg[7:0]))
        else $error("write commit missing or wrong byte");

    a_cs_gate: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == PORT_IDLE) && !csLow |=> state_reg == PORT_IDLE)
        else $error("access taken without chip select");

    a_pick_b: assert property (@(posedge clk) disable iff (!resetn)
        (s_writeDone and (!chanA_reg && !alternateFunctionBroadcast))
        |-> writeChanB && !writeChanA)
        else $error("low channel pick did not select channel B");

    a_broadcast: assert property (@(posedge clk) disable iff (!resetn)
        (s_writeDone and alternateFunctionBroadcast) |-> writeChanA && writeChanB)
        else $error("broadcast write missed a channel");

    a_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        ##1 irqOutChanA == $past(pendingA))
        else $error("channel A interrupt does not follow request");

    a_irq_b: assert property (@(posedge clk) disable iff (!resetn)
        ##1 irqOutChanB == $past(pendingB))
        else $error("channel B interrupt does not follow request");

    a_tx_flags: assert property (@(posedge clk) disable iff (!resetn)
        ##1 (txSpaceFlagAN != $past(txSpaceA)) && (txSpaceFlagBN != $past(txSpaceB)))
        else $error("transmit space flag not inverted status");

endmodule

// [tb/host_bus_model.sv]
// host processor model that drives the strobe bus pins
`timescale 1ns/1ns
module host_bus_model
(
    input wire logic clk,
    output logic csN,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic channelPick,
    output logic [2:0] registerIndex,
    output logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    logic [7:0] wrByte;
    logic driving;
    // a released bus shows the inverse of the last byte, never a stale copy
    assign dataIn = driving ? wrByte : ~wrByte;
    initial
    begin
        csN = 1'b1;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        channelPick = 1'b0;
        registerIndex = 3'h0;
        wrByte = 8'h00;
        driving = 1'b0;
    end
    // one whole access; strobes stay long enough for the two-flop sync
    task automatic access(input logic isRead, input logic cs, input logic pick,
        input logic [2:0] idx, input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        begin
            @(posedge clk);
            #1;
            csN = cs;
            channelPick = pick;
            registerIndex = idx;
            wrByte = wdata;
            driving = !isRead;
            @(posedge clk);
            #1;
            if (isRead)
                readStrobeN = 1'b0;
            else
                writeStrobeN = 1'b0;
            n = 0;
            while (isRead && !cs && dataOe !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            repeat (3) @(posedge clk);
            #1;
            rdata = dataOut;
            readStrobeN = 1'b1;
            writeStrobeN = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            csN = 1'b1;
            driving = 1'b0;
            repeat (4) @(posedge clk);
            #1;
        end
    endtask
endmodule

// [tb/dual_uart_host_bus_port_tb.sv]
// self-checking bench for the dual-channel host bus port
`timescale 1ns/1ns
module dual_uart_host_bus_port_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic csN, readStrobeN, writeStrobeN, channelPick, dataOe;
    logic [2:0] registerIndex, regIndex;
    logic [7:0] dataIn, dataOut, regWrData;
    logic broadcast = 1'b0;
    logic writeChanA, writeChanB, readChanA, readChanB;
    logic pendingA = 1'b0;
    logic pendingB = 1'b0;
    logic txSpaceA = 1'b0;
    logic txSpaceB = 1'b0;
    logic irqA, irqB, flagAN, flagBN;
    logic [10:0] lastWr = 11'h0;
    int cntA = 0;
    int cntB = 0;
    int oeSeen = 0;
    int rdA = 0;
    int rdB = 0;
    int cycles = 0;
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    dual_uart_host_bus_port i_dut (.clk(clk), .resetn(resetn), .csN(csN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .channelPick(channelPick),
        .registerIndex(registerIndex), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .alternateFunctionBroadcast(broadcast), .regIndex(regIndex), .regWrData(regWrData),
        .writeChanA(writeChanA), .writeChanB(writeChanB), .readChanA(readChanA),
        .readChanB(readChanB), .readDataA({5'h14, regIndex}), .readDataB({5'h16, regIndex}),
        .pendingA(pendingA), .pendingB(pendingB), .txSpaceA(txSpaceA), .txSpaceB(txSpaceB),
        .irqOutChanA(irqA), .irqOutChanB(irqB), .txSpaceFlagAN(flagAN), .txSpaceFlagBN(flagBN));
    host_bus_model i_host (.clk(clk), .csN(csN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .channelPick(channelPick), .registerIndex(registerIndex),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
    // watch commit pulses, bus drive and the cycle ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (writeChanA === 1'b1) cntA++;
        if (writeChanB === 1'b1) cntB++;
        if (writeChanA === 1'b1 || writeChanB === 1'b1) lastWr = {regIndex, regWrData};
        if (dataOe === 1'b1) oeSeen++;
        if (readChanA === 1'b1) rdA++;
        if (readChanB === 1'b1) rdB++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("counts: compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // read every index on alternating channels; bus released afterwards
    task automatic t_read();
        logic [7:0] r;
        int ra, rb;
        for (int i = 0; i < 8; i++)
        begin
            ra = rdA;
            rb = rdB;
            i_host.access(1'b1, 1'b0, i[0], i[2:0], 8'h00, r);
            check(16'(rdA - ra), 16'(i[0]));
            check(16'(rdB - rb), 16'(!i[0]));
            check(16'(r), 16'({i[0] ? 5'h14 : 5'h16, i[2:0]}));
            check(16'(dataOe), 16'h0000);
        end
        $display("test read done");
    endtask
    // write with and without the broadcast bit on both channel picks
    task automatic t_write();
        logic [7:0] r;
        int a0, b0;
        for (int i = 0; i < 4; i++)
        begin
            a0 = cntA;
            b0 = cntB;
            broadcast = i[1];
            i_host.access(1'b0, 1'b0, i[0], 3'(i + 3), 8'h5A ^ 8'(i), r);
            check(16'(cntA - a0), 16'(i[1] | i[0]));
            check(16'(cntB - b0), 16'(i[1] | !i[0]));
            check(16'(lastWr), 16'({3'(i + 3), 8'h5A ^ 8'(i)}));
        end
        broadcast = 1'b0;
        $display("test write done");
    endtask
    // strobes without chip select must be ignored
    task automatic t_nocs();
        logic [7:0] r;
        int a0, b0, o0, r0;
        r0 = rdA + rdB;
        a0 = cntA;
        b0 = cntB;
        o0 = oeSeen;
        i_host.access(1'b0, 1'b1, 1'b1, 3'h2, 8'hC3, r);
        i_host.access(1'b1, 1'b1, 1'b0, 3'h2, 8'h00, r);
        check(16'(cntA - a0 + cntB - b0), 16'h0000);
        check(16'(oeSeen - o0), 16'h0000);
        check(16'(rdA + rdB - r0), 16'h0000);
        $display("test no select done");
    endtask
    // status levels pass to the interrupt and transmit flag pins
    task automatic t_status();
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            #1;
            pendingA = !i[0];
            pendingB = i[0];
            txSpaceA = !i[0];
            txSpaceB = i[0];
            repeat (3) @(posedge clk);
            #1;
            check(16'({irqA, irqB}), 16'({!i[0], i[0]}));
            check(16'({flagAN, flagBN}), 16'({i[0], !i[0]}));
        end
        $display("test status done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        check(16'({dataOe, flagAN, flagBN}), 16'h0003);
        resetn = 1'b1;
        t_read();
        t_write();
        t_nocs();
        t_status();
        end_sim();
    end
endmodule
